// *** logic/ivs_consts.svh ***
// Constants for the value/sequence sender: offsets, fields, resets, timing.
// Assumes a 25 MHz aclk and an 8-bit AXI4-Lite byte address.
`ifndef IVS_CONSTS_SVH
`define IVS_CONSTS_SVH

`define IVS_CLK_HZ      25000000
`define IVS_MS_PER_S    1000
`define IVS_MS_CYCLES   (`IVS_CLK_HZ / `IVS_MS_PER_S)
`define IVS_HS_MS       4'h9
`define IVS_S_MS        10'h3e7
`define IVS_NOBJ        8

`define IVS_LONG_MS_RST 16'h0320
`define IVS_CYC_S_RST   17'h00078
`define IVS_CTRL_RST    11'h001
`define IVS_DLY_RST     19'h00000
`define IVS_VAL_RST     32'h00010000

`define IVS_OFF_CTRL    8'h00
`define IVS_OFF_LONG    8'h04
`define IVS_OFF_CYC     8'h08
`define IVS_OFF_STAT    8'h0c
`define IVS_OFF_DLY     8'h20
`define IVS_OFF_VAL     8'h40

`define IVS_CTRL_EVT    4
`define IVS_CTRL_LOCK   5
`define IVS_CTRL_UNLK   7
`define IVS_CTRL_CYC    9
`define IVS_DLY_FMT     16

`define IVS_RESP_OKAY   2'h0
`define IVS_RESP_SLVERR 2'h2

`endif

// *** logic/ivs_pkg.sv ***
// Types shared by the value/sequence sender modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ivs_pkg;

  typedef enum logic [2:0] {
    IVS_F_1BIT = 3'h0,
    IVS_F_2BIT = 3'h1,
    IVS_F_U8   = 3'h2,
    IVS_F_PCT  = 3'h3,
    IVS_F_S8   = 3'h4,
    IVS_F_U16  = 3'h5,
    IVS_F_S16  = 3'h6,
    IVS_F_FLT  = 3'h7
  } ivs_fmt_t;

  typedef enum logic [1:0] {
    IVS_R_NONE = 2'h0,
    IVS_R_A    = 2'h1,
    IVS_R_B    = 2'h2
  } ivs_react_t;

  typedef enum logic [1:0] {
    IVS_C_NONE = 2'h0,
    IVS_C_OFF  = 2'h1,
    IVS_C_ON   = 2'h2,
    IVS_C_BOTH = 2'h3
  } ivs_cyc_t;

  typedef enum logic [2:0] {
    IVS_P_IDLE = 3'b001,
    IVS_P_HELD = 3'b010,
    IVS_P_LONG = 3'b100
  } ivs_press_t;

endpackage

// *** logic/ivs_slot.sv ***
// One output object's send-delay timer.
// Assumes a hundredth-second tick pulse from the parent's time base.
`timescale 1ns/100ps
`include "ivs_consts.svh"
module ivs_slot
  import ivs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        sel_in,
  input  wire logic        tick,
  input  wire logic [15:0] delay,
  input  wire logic        ack,
  output logic             due,
  output logic             sel
);

  logic [15:0] cnt_q;
  logic        armed_q;
  logic        sel_q;

  // Restart beats an ack so a new event is never dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      cnt_q   <= 16'h0000;
      sel_q   <= 1'b0;
    end else if (start) begin
      armed_q <= 1'b1;
      cnt_q   <= delay;
      sel_q   <= sel_in;
    end else if (ack) begin
      armed_q <= 1'b0;
    end else if (armed_q && tick && cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign due = armed_q && cnt_q == 16'h0000;
  assign sel = sel_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_loads: assert property (
    start |=> armed_q && cnt_q == $past(delay))
    else $error("Slot did not load its delay on start");
  a_due_holds: assert property (due && !ack && !start |=> due)
    else $error("Due object lost before it was sent");
  a_count_steps: assert property (
    armed_q && !start && !ack && tick && cnt_q != 16'h0000
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("Delay count did not step on tick");

endmodule

// *** logic/ivs_sender.sv ***
// Value/sequence sender for one contact input, AXI4-Lite configured.
// Assumes contact and lock commands synchronous to aclk; tx_* feeds a
// telegram sender that takes a word when tx_valid and tx_ready are high.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ivs_consts.svh"
module ivs_sender
  import ivs_pkg::*;
#(
  parameter int MS_CYCLES = `IVS_MS_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        contact_in,
  input  wire logic        lock_cmd,
  input  wire logic        unlock_cmd,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [2:0]       tx_obj,
  output logic [2:0]       tx_fmt,
  output logic [15:0]      tx_data,
  output logic             tx_cyclic
);

  function automatic logic obj_hit(input logic [7:0] a, input logic [7:0] b);
    obj_hit = a[7:5] == b[7:5] && a[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    merge = o;
    for (int b = 0; b < 4; b++)
      if (s[b]) merge[b*8 +: 8] = n[b*8 +: 8];
  endfunction

  // Narrow formats drop upper bits; signed bytes widen with their sign
  function automatic logic [15:0] fmt_value(input logic [2:0]  f,
                                            input logic [15:0] v);
    case (f)
      IVS_F_1BIT: fmt_value = {15'h0000, v[0]};
      IVS_F_2BIT: fmt_value = {14'h0000, v[1:0]};
      IVS_F_U8,
      IVS_F_PCT:  fmt_value = {8'h00, v[7:0]};
      IVS_F_S8:   fmt_value = {{8{v[7]}}, v[7:0]};
      default:    fmt_value = v;
    endcase
  endfunction

  // Register file
  logic [10:0] ctrl_q;
  logic [15:0] long_q;
  logic [16:0] cyc_s_q;
  logic [18:0] dly_q [`IVS_NOBJ];
  logic [31:0] val_q [`IVS_NOBJ];
  logic        aw_held_q, w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_en;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign wr_en = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_held_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else if (wr_en) begin
      w_held_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IVS_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q[7:4] == 4'h0 || obj_hit(aw_addr_q,
                       `IVS_OFF_DLY) || obj_hit(aw_addr_q, `IVS_OFF_VAL))
                      ? `IVS_RESP_OKAY : `IVS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= `IVS_CTRL_RST;
      long_q  <= `IVS_LONG_MS_RST;
      cyc_s_q <= `IVS_CYC_S_RST;
      for (int i = 0; i < `IVS_NOBJ; i++) begin
        dly_q[i] <= `IVS_DLY_RST;
        val_q[i] <= `IVS_VAL_RST;
      end
    end else if (wr_en) begin
      if (aw_addr_q == `IVS_OFF_CTRL)
        ctrl_q <= 11'(merge({21'h000000, ctrl_q}, w_data_q, w_strb_q));
      if (aw_addr_q == `IVS_OFF_LONG)
        long_q <= 16'(merge({16'h0000, long_q}, w_data_q, w_strb_q));
      if (aw_addr_q == `IVS_OFF_CYC)
        cyc_s_q <= 17'(merge({15'h0000, cyc_s_q}, w_data_q, w_strb_q));
      if (obj_hit(aw_addr_q, `IVS_OFF_DLY))
        dly_q[aw_addr_q[4:2]] <= 19'(merge({13'h0000, dly_q[aw_addr_q[4:2]]},
                                           w_data_q, w_strb_q));
      if (obj_hit(aw_addr_q, `IVS_OFF_VAL))
        val_q[aw_addr_q[4:2]] <= merge(val_q[aw_addr_q[4:2]], w_data_q,
                                       w_strb_q);
    end
  end

  // Press state, lock and pending flags are declared here for status reads
  ivs_press_t  press_q;
  logic        locked_q;
  logic [7:0]  due;
  logic        last_sel_q;

  always_comb begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `IVS_OFF_CTRL)
      rd_word = {21'h000000, ctrl_q};
    else if (s_axi_araddr == `IVS_OFF_LONG)
      rd_word = {16'h0000, long_q};
    else if (s_axi_araddr == `IVS_OFF_CYC)
      rd_word = {15'h0000, cyc_s_q};
    else if (s_axi_araddr == `IVS_OFF_STAT)
      rd_word = {20'h00000, last_sel_q, due, press_q != IVS_P_IDLE,
                 locked_q, contact_in};
    else if (obj_hit(s_axi_araddr, `IVS_OFF_DLY))
      rd_word = {13'h0000, dly_q[s_axi_araddr[4:2]]};
    else if (obj_hit(s_axi_araddr, `IVS_OFF_VAL))
      rd_word = val_q[s_axi_araddr[4:2]];
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IVS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? `IVS_RESP_OKAY : `IVS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration fields; an out-of-range count is clamped to 1..8
  logic [3:0]  cnt_eff;
  logic        evt_press;
  ivs_react_t  lock_r, unlk_r;
  ivs_cyc_t    cyc_mode;

  assign cnt_eff   = ctrl_q[3:0] == 4'h0 ? 4'h1 :
                     ctrl_q[3] ? 4'h8 : ctrl_q[3:0];
  assign evt_press = ctrl_q[`IVS_CTRL_EVT];
  assign lock_r    = ivs_react_t'(ctrl_q[`IVS_CTRL_LOCK +: 2]);
  assign unlk_r    = ivs_react_t'(ctrl_q[`IVS_CTRL_UNLK +: 2]);
  assign cyc_mode  = ivs_cyc_t'(ctrl_q[`IVS_CTRL_CYC +: 2]);

  // Time base: ms, hundredth-second and second ticks
  logic [14:0] ms_cnt_q;
  logic [3:0]  hs_cnt_q;
  logic [9:0]  s_cnt_q;
  logic        tick_ms_q, tick_hs_q, tick_s_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_q  <= 15'h0000;
      hs_cnt_q  <= 4'h0;
      s_cnt_q   <= 10'h000;
      tick_ms_q <= 1'b0;
      tick_hs_q <= 1'b0;
      tick_s_q  <= 1'b0;
    end else begin
      tick_ms_q <= ms_cnt_q == 15'(MS_CYCLES - 1);
      ms_cnt_q  <= ms_cnt_q == 15'(MS_CYCLES - 1) ? 15'h0000
                                                  : ms_cnt_q + 15'h0001;
      tick_hs_q <= tick_ms_q && hs_cnt_q == `IVS_HS_MS;
      tick_s_q  <= tick_ms_q && s_cnt_q == `IVS_S_MS;
      if (tick_ms_q) begin
        hs_cnt_q <= hs_cnt_q == `IVS_HS_MS ? 4'h0 : hs_cnt_q + 4'h1;
        s_cnt_q  <= s_cnt_q == `IVS_S_MS ? 10'h000 : s_cnt_q + 10'h001;
      end
    end
  end

  // Event detection
  logic        contact_q, rise, fall;
  logic [15:0] press_ms_q;
  logic        ev_a, ev_b, user_gate, fire_a, fire_b, fire;

  assign rise = contact_in && !contact_q;
  assign fall = !contact_in && contact_q;

  always_comb begin
    ev_a = 1'b0;
    ev_b = 1'b0;
    if (!evt_press) begin
      ev_a = rise;
      ev_b = fall;
    end else begin
      case (press_q)
        IVS_P_HELD: begin
          ev_a = fall;
          ev_b = !fall && press_ms_q >= long_q;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      contact_q  <= 1'b0;
      press_q    <= IVS_P_IDLE;
      press_ms_q <= 16'h0000;
    end else begin
      contact_q <= contact_in;
      if (tick_ms_q && press_ms_q != 16'hffff)
        press_ms_q <= press_ms_q + 16'h0001;
      case (press_q)
        IVS_P_IDLE: if (evt_press && rise) begin
          press_q    <= IVS_P_HELD;
          press_ms_q <= 16'h0000;
        end
        IVS_P_HELD: if (fall) press_q <= IVS_P_IDLE;
          else if (press_ms_q >= long_q) press_q <= IVS_P_LONG;
        IVS_P_LONG: if (fall) press_q <= IVS_P_IDLE;
        default: press_q <= IVS_P_IDLE;
      endcase
    end
  end

  // A lock arriving with an input edge blocks that edge; lock beats unlock
  assign user_gate = !locked_q && !lock_cmd;
  assign fire_a = (ev_a && user_gate) || (lock_cmd && lock_r == IVS_R_A) ||
                  (unlock_cmd && !lock_cmd && unlk_r == IVS_R_A);
  assign fire_b = (ev_b && user_gate) || (lock_cmd && lock_r == IVS_R_B) ||
                  (unlock_cmd && !lock_cmd && unlk_r == IVS_R_B);
  assign fire = fire_a || fire_b;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      locked_q <= 1'b0;
    else if (lock_cmd)
      locked_q <= 1'b1;
    else if (unlock_cmd)
      locked_q <= 1'b0;
  end

  // Object delay slots
  logic [7:0] ack, slot_sel;

  generate
    for (genvar i = 0; i < `IVS_NOBJ; i++) begin : g_slot
      ivs_slot u_slot (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (fire && 4'(i) < cnt_eff),
        .sel_in  (fire_b),
        .tick    (tick_hs_q),
        .delay   (dly_q[i][15:0]),
        // Slots past a shrunk count are dropped so nothing stale is sent
        .ack     (ack[i] || 4'(i) >= cnt_eff),
        .due     (due[i]),
        .sel     (slot_sel[i])
      );
    end
  endgenerate

  // Cyclic repeat of object 0
  logic [16:0] cyc_cnt_q;
  logic        cyc_en, cyc_hit, cyc_pend_q, cyc_take;

  assign cyc_en  = cnt_eff == 4'h1 && cyc_mode != IVS_C_NONE;
  assign cyc_hit = cyc_mode == IVS_C_BOTH ||
                   (cyc_mode == IVS_C_OFF && !last_sel_q) ||
                   (cyc_mode == IVS_C_ON && last_sel_q);

  always_ff @(posedge aclk) begin
    if (!aresetn || !cyc_en) begin
      cyc_cnt_q  <= 17'h00000;
      cyc_pend_q <= 1'b0;
    end else begin
      if (tick_s_q)
        cyc_cnt_q <= cyc_cnt_q + 17'h00001 >= cyc_s_q ? 17'h00000
                                                     : cyc_cnt_q + 17'h00001;
      // A new period wins over the take of the old one
      cyc_pend_q <= (tick_s_q && cyc_cnt_q + 17'h00001 >= cyc_s_q &&
                     cyc_hit) || (cyc_pend_q && !cyc_take);
    end
  end

  // Transmit stage; lowest due object first, cyclic repeat last
  logic       load;
  logic [2:0] pick;

  assign load = !tx_valid || tx_ready;

  always_comb begin
    pick = 3'h0;
    for (int i = `IVS_NOBJ - 1; i >= 0; i--)
      if (due[i]) pick = 3'(i);
  end

  assign ack      = load && |due ? 8'h01 << pick : 8'h00;
  assign cyc_take = load && !(|due) && cyc_pend_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid   <= 1'b0;
      tx_obj     <= 3'h0;
      tx_fmt     <= 3'h0;
      tx_data    <= 16'h0000;
      tx_cyclic  <= 1'b0;
      last_sel_q <= 1'b0;
    end else if (load) begin
      tx_valid  <= |due || cyc_pend_q;
      tx_cyclic <= !(|due) && cyc_pend_q;
      if (|due) begin
        tx_obj  <= pick;
        tx_fmt  <= dly_q[pick][`IVS_DLY_FMT +: 3];
        tx_data <= fmt_value(dly_q[pick][`IVS_DLY_FMT +: 3], slot_sel[pick]
                   ? val_q[pick][31:16] : val_q[pick][15:0]);
        if (pick == 3'h0) last_sel_q <= slot_sel[0];
      end else if (cyc_pend_q) begin
        tx_obj  <= 3'h0;
        tx_fmt  <= dly_q[0][`IVS_DLY_FMT +: 3];
        tx_data <= fmt_value(dly_q[0][`IVS_DLY_FMT +: 3], last_sel_q
                   ? val_q[0][31:16] : val_q[0][15:0]);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_held_past_long;
    evt_press && press_q == IVS_P_HELD && !fall && press_ms_q >= long_q;
  endsequence

  a_long_press: assert property (
    s_held_past_long |-> ev_b ##1 press_q == IVS_P_LONG)
    else $error("Held press past threshold not classed long");
  a_short_press: assert property (
    evt_press && press_q == IVS_P_HELD && fall
    |-> ev_a ##1 press_q == IVS_P_IDLE)
    else $error("Release before threshold not classed short");
  a_contact_mode: assert property (
    !evt_press && rise |-> ev_a && !ev_b)
    else $error("Contact close not taken as first event");
  a_lock_react: assert property (
    lock_cmd && lock_r == IVS_R_B |-> fire_b ##1 locked_q)
    else $error("Lock reaction or lock state missing");
  a_unlock_react: assert property (
    unlock_cmd && !lock_cmd && unlk_r == IVS_R_A |-> fire_a ##1 !locked_q)
    else $error("Unlock reaction or unlock state missing");
  a_locked_quiet: assert property (
    locked_q && !lock_cmd && !unlock_cmd |-> !fire)
    else $error("Input event sent while locked");
  a_cyc_one_obj: assert property (
    $rose(cyc_pend_q) |-> $past(cnt_eff) == 4'h1 && $past(tick_s_q))
    else $error("Cyclic send raised without one object or second tick");
  a_cyc_which: assert property (
    $rose(cyc_pend_q) && $past(cyc_mode) == IVS_C_OFF |-> !$past(last_sel_q))
    else $error("Cyclic repeat of value not selected");
  a_fmt_one_bit: assert property (
    tx_valid && tx_fmt == IVS_F_1BIT |-> tx_data[15:1] == 15'h0000)
    else $error("One-bit object sent with upper bits set");
  a_slot_limit: assert property (
    fire |=> (due >> cnt_eff) == 8'h00 || $past(cnt_eff) != cnt_eff)
    else $error("Object beyond configured count became due");

endmodule

// *** bench/ivs_tx_sink.sv ***
// Telegram sink model standing after the value/sequence sender.
// Assumes tx_* held until taken; slow makes it stall at random.
`timescale 1ns/100ps
module ivs_tx_sink (
  input  wire logic        aclk,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [2:0]  tx_obj,
  input  wire logic [2:0]  tx_fmt,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_cyclic,
  output logic             tx_ready
);
  logic [22:0] got_q[$];

  // Random stalls shake out words that change before they are taken
  always @(posedge aclk) begin
    if (tx_valid && tx_ready)
      got_q.push_back({tx_cyclic, tx_obj, tx_fmt, tx_data});
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the value/sequence sender.
// Assumes the telegram sink model and a 40 ns aclk.
`timescale 1ns/100ps
`include "ivs_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb
  import ivs_pkg::*;
;
  localparam int MS = 4;
  logic        aclk = 0, aresetn = 0, slow = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        contact_in = 0, lock_cmd = 0, unlock_cmd = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, tx_valid, tx_cyclic, tx_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0]  tx_obj, tx_fmt;
  logic [15:0] tx_data;
  logic [31:0] v [8];
  int          fail_count = 0;
  int          check_count = 0;
  int          i;

  ivs_sender #(.MS_CYCLES(MS)) dut_u (.*);
  ivs_tx_sink sink_u (.*);

  always #20 aclk = ~aclk;

  function automatic logic [22:0] wd(input logic c, input logic [2:0] o,
                                     input logic [2:0] f, input logic [15:0] x);
    logic [15:0] m;
    case (f)
      IVS_F_1BIT: m = {15'h0, x[0]};
      IVS_F_2BIT: m = {14'h0, x[1:0]};
      IVS_F_U8, IVS_F_PCT: m = {8'h0, x[7:0]};
      IVS_F_S8: m = {{8{x[7]}}, x[7:0]};
      default: m = x;
    endcase
    return {c, o, f, m};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // Bounded wait: a cyclic repeat may sit a whole period away
  task automatic want(input logic [22:0] e);
    logic [22:0] w;
    int          n;
    n = 0;
    w = 'x;
    while (sink_u.got_q.size() == 0 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    if (sink_u.got_q.size() != 0) w = sink_u.got_q.pop_front();
    `CHK("word", e, w)
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge aclk);
    `CHK("idle", 0, sink_u.got_q.size())
  endtask

  task automatic pin(input logic c, input int n);
    @(posedge aclk);
    contact_in <= c;
    repeat (n) @(posedge aclk);
  endtask

  task automatic pulse(input logic lk);
    @(posedge aclk);
    if (lk) lock_cmd <= 1'b1;
    else unlock_cmd <= 1'b1;
    @(posedge aclk);
    lock_cmd <= 1'b0;
    unlock_cmd <= 1'b0;
  endtask

  task automatic react(input logic [1:0] r);
    if (r == IVS_R_A) want(wd(0, 0, 5, v[0][15:0]));
    else if (r == IVS_R_B) want(wd(0, 0, 5, v[0][31:16]));
    else quiet(60);
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    complete_run();
  end

  initial begin
    void'($urandom(53851));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IVS_OFF_CTRL, 32'(`IVS_CTRL_RST));
    rd(`IVS_OFF_LONG, 32'(`IVS_LONG_MS_RST));
    rd(`IVS_OFF_CYC, 32'(`IVS_CYC_S_RST));
    rd(`IVS_OFF_DLY, 32'(`IVS_DLY_RST));
    rd(`IVS_OFF_VAL, `IVS_VAL_RST);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'h1, 2'h2);
    pin(1, 1);
    want(wd(0, 0, 0, 16'h0));
    pin(0, 1);
    want(wd(0, 0, 0, 16'h1));
    quiet(100);
    // Idle status: only the last-sent flag is up, value 2 went last
    rd(`IVS_OFF_STAT, 32'h800);
    $display("test defaults done");
    // Later objects get shorter delays, so sending runs backwards
    for (i = 0; i < 8; i++) begin
      v[i] = $urandom();
      wr(8'(`IVS_OFF_DLY + 4 * i), {13'h0, 3'(i), 16'(8 - i)});
      wr(8'(`IVS_OFF_VAL + 4 * i), v[i]);
    end
    wr(`IVS_OFF_CTRL, 32'h8);
    slow <= 1'b1;
    pin(1, 0);
    for (i = 7; i >= 0; i--) want(wd(0, 3'(i), 3'(i), v[i][15:0]));
    pin(0, 0);
    for (i = 7; i >= 0; i--) want(wd(0, 3'(i), 3'(i), v[i][31:16]));
    $display("test sequence done");
    wr(`IVS_OFF_CTRL, 32'h11);
    wr(`IVS_OFF_LONG, 32'h5);
    wr(`IVS_OFF_DLY, 32'h00050000);
    pin(1, 12);
    pin(0, 0);
    want(wd(0, 0, 5, v[0][15:0]));
    pin(1, 40);
    want(wd(0, 0, 5, v[0][31:16]));
    pin(0, 0);
    quiet(60);
    $display("test press done");
    for (i = 0; i < 3; i++) begin
      wr(`IVS_OFF_CTRL, 32'h1 | (i << 5) | (((i + 1) % 3) << 7));
      pulse(1);
      react(2'(i));
      pin(1, 20);
      pin(0, 20);
      quiet(20);
      pulse(0);
      react(2'((i + 1) % 3));
    end
    $display("test lock done");
    // Last word sent on object 0 was value 2
    wr(`IVS_OFF_CYC, 32'h1);
    wr(`IVS_OFF_CTRL, 32'h601);
    want(wd(1, 0, 5, v[0][31:16]));
    want(wd(1, 0, 5, v[0][31:16]));
    wr(`IVS_OFF_CTRL, 32'h401);
    want(wd(1, 0, 5, v[0][31:16]));
    wr(`IVS_OFF_CTRL, 32'h201);
    quiet(5000);
    // Sending value 1 makes it the value that repeats in this mode
    pin(1, 1);
    want(wd(0, 0, 5, v[0][15:0]));
    want(wd(1, 0, 5, v[0][15:0]));
    wr(`IVS_OFF_CTRL, 32'h602);
    quiet(5000);
    $display("test cyclic done");
    complete_run();
  end
endmodule
